// ==== dma_channel_transfer_control.v ====
`timescale 1ns/1ns
`default_nettype none
`include "dma_consts.vh"

module dma_channel_transfer_control (
   input  wire        i_clock,
   input  wire        i_rst_b,
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output wire        o_pready,
   output reg  [31:0] o_prdata,
   output wire        o_pslverr,
   input  wire        i_external_request_n,
   input  wire        i_bus_grant,
   input  wire        i_bus_ack,
   input  wire        i_bus_err,
   input  wire [31:0] i_bus_rdata,
   output wire        o_bus_req,
   output wire        o_bus_priority,
   output wire        o_bus_cycle,
   output wire        o_bus_write,
   output wire [31:0] o_bus_addr,
   output wire [1:0]  o_bus_size,
   output wire [31:0] o_bus_wdata,
   output wire [1:0]  o_bus_tt,
   output wire [2:0]  o_bus_tm,
   output wire        o_irq
);

   localparam [3:0] S_IDLE  = 4'b0001;
   localparam [3:0] S_SETUP = 4'b0010;
   localparam [3:0] S_READ  = 4'b0100;
   localparam [3:0] S_WRITE = 4'b1000;

   reg [3:0]          state_reg;
   reg [31:0]         source_address_reg;
   reg [31:0]         dest_address_reg;
   reg [`COUNT_W-1:0] byte_count_reg;
   reg [`CTL_W-1:0]   channel_control_reg;
   reg [31:0]         hold_reg;
   reg [4:0]          rd_left_reg;
   reg [4:0]          wr_left_reg;
   reg                done_reg;
   reg                cfg_err_reg;
   reg                source_bus_error_flag;
   reg                dest_bus_error_flag;
   reg                hold_valid_reg;
   reg                ext_start_reg;
   reg                bw_drop_reg;

   wire               ext_req;
   wire [1:0]         src_pick;
   wire [1:0]         dst_pick;

   // decoded control fields
   wire [1:0] source_operand_size   = channel_control_reg[`CTL_SOURCE_OPERAND_SIZE_LO+1:`CTL_SOURCE_OPERAND_SIZE_LO];
   wire [1:0] dest_operand_size     = channel_control_reg[`CTL_DEST_OPERAND_SIZE_LO+1:`CTL_DEST_OPERAND_SIZE_LO];
   wire [2:0] bandwidth_limit_field = channel_control_reg[`CTL_BW_LO+2:`CTL_BW_LO];
   wire       auto_align_enable     = channel_control_reg[`CTL_AUTO_ALIGN];
   wire       ext_request_enable    = channel_control_reg[`CTL_EXT_EN];
   wire       single_addr           = channel_control_reg[`CTL_SINGLE_ADDR];
   wire       cycle_steal           = channel_control_reg[`CTL_CYCLE_STEAL];
   wire       start_bit             = channel_control_reg[`CTL_START];

   wire st_idle  = state_reg[0];
   wire st_setup = state_reg[1];
   wire st_read  = state_reg[2];
   wire st_write = state_reg[3];

   function [4:0] size_bytes;
      input [1:0] s;
      begin
         case (s)
            `SZ_BYTE: size_bytes = 5'h01;
            `SZ_WORD: size_bytes = 5'h02;
            `SZ_LINE: size_bytes = 5'h10;
            default:  size_bytes = 5'h04;
         endcase
      end
   endfunction

   // low address or count bits that break the operand alignment
   function misal;
      input [3:0] v;
      input [4:0] b;
      begin
         misal = |(v & (b[3:0] - 4'h1));
      end
   endfunction

   wire [4:0] src_b   = size_bytes(source_operand_size);
   wire [4:0] dst_b   = size_bytes(dest_operand_size);
   wire       src_sel = (src_b >= dst_b);
   wire [4:0] rd_b    = size_bytes(src_pick);
   wire [4:0] wr_b    = size_bytes(dst_pick);
   wire [4:0] acc_b   = st_write ? wr_b : rd_b;

   // limit for the size pickers: whole chunk at setup, then what is left
   wire [4:0] pick_lim = st_setup ? `LINE_BYTES : (st_read ? rd_left_reg : wr_left_reg);

   // configuration check; the aligned side is exempt
   wire chk_src = !auto_align_enable || !src_sel;
   wire chk_dst = !single_addr && (!auto_align_enable || src_sel);
   wire cfg_bad = (chk_src && (misal(source_address_reg[3:0], src_b) ||
                               misal(byte_count_reg[3:0], src_b))) ||
                  (chk_dst && (misal(dest_address_reg[3:0], dst_b) ||
                               misal(byte_count_reg[3:0], dst_b)));

   // bytes moved by one read/write transfer
   wire [4:0] chunk_b = single_addr ? src_b :
                        (auto_align_enable ? (src_sel ? rd_b : wr_b) :
                         (src_sel ? src_b : dst_b));

   // address step enables; the aligned side always steps
   wire sar_inc = channel_control_reg[`CTL_SRC_INC] || (auto_align_enable && src_sel);
   wire dar_inc = channel_control_reg[`CTL_DST_INC] || (auto_align_enable && !src_sel);

   // count after this access and the bandwidth boundary test
   wire [`COUNT_W-1:0] count_dec = byte_count_reg - {{(`COUNT_W-5){1'b0}}, acc_b};
   wire [4:0]          bw_shift  = {2'b00, bandwidth_limit_field} + `BW_SHIFT_BASE;
   wire [`COUNT_W-1:0] bw_block  = {{(`COUNT_W-1){1'b0}}, 1'b1} << bw_shift;
   // an exact multiple only; a count that steps over it keeps the request
   wire bw_hit   = (bandwidth_limit_field != 3'h0) &&
                   ((count_dec & (bw_block - 24'h000001)) == 24'h000000);
   wire fin_done = (count_dec == 24'h000000);
   wire [3:0] fin_state = (fin_done || cycle_steal) ? S_IDLE : S_SETUP;

   // a bus cycle completes only while the arbiter grants us
   wire acc_go = (st_read || st_write) && i_bus_grant && i_bus_ack;

   // software start or enabled external line, while idle and not done
   wire go = st_idle && !done_reg && (start_bit || (ext_request_enable && ext_req));

   // apb decode; the slave never waits
   wire apb_wr  = i_psel && i_penable && i_pwrite;
   wire apb_hit = (i_paddr == `OFS_SRC_ADDR) || (i_paddr == `OFS_DST_ADDR) ||
                  (i_paddr == `OFS_COUNT) || (i_paddr == `OFS_CONTROL) ||
                  (i_paddr == `OFS_STATUS);
   wire st_clr  = apb_wr && (i_paddr == `OFS_STATUS) && i_pwdata[`ST_DONE];

   dma_req_sync u_req_sync (
      .i_clock     (i_clock),
      .i_rst_b     (i_rst_b),
      .i_request_n (i_external_request_n),
      .o_request   (ext_req)
   );

   dma_size_sel u_src_size (
      .i_align     (auto_align_enable),
      .i_addr      (source_address_reg[3:0]),
      .i_prog_size (source_operand_size),
      .i_count     (byte_count_reg),
      .i_limit     (pick_lim),
      .o_size      (src_pick)
   );

   dma_size_sel u_dst_size (
      .i_align     (auto_align_enable),
      .i_addr      (dest_address_reg[3:0]),
      .i_prog_size (dest_operand_size),
      .i_count     (byte_count_reg),
      .i_limit     (pick_lim),
      .o_size      (dst_pick)
   );

   // status word as software sees it
   reg [31:0] status_word;
   always @* begin
      status_word = 32'h00000000;
      status_word[`ST_DONE]       = done_reg;
      status_word[`ST_BUSY]       = !st_idle;
      status_word[`ST_CFG_ERR]    = cfg_err_reg;
      status_word[`ST_SRC_ERR]    = source_bus_error_flag;
      status_word[`ST_DST_ERR]    = dest_bus_error_flag;
      status_word[`ST_HOLD_VALID] = hold_valid_reg;
   end

   // read data is captured in the setup phase, stable through access
   always @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_prdata <= 32'h00000000;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         case (i_paddr)
            `OFS_SRC_ADDR: o_prdata <= source_address_reg;
            `OFS_DST_ADDR: o_prdata <= dest_address_reg;
            `OFS_COUNT:    o_prdata <= {8'h00, byte_count_reg};
            `OFS_CONTROL:  o_prdata <= {16'h0000, channel_control_reg};
            `OFS_STATUS:   o_prdata <= status_word;
            default:       o_prdata <= 32'h00000000;
         endcase
      end
   end

   // channel engine; software writes come last so they win over hardware,
   // except that a hardware status set wins over the done write-one
   always @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg             <= S_IDLE;
         source_address_reg    <= `ADDR_RESET;
         dest_address_reg      <= `ADDR_RESET;
         byte_count_reg        <= `COUNT_RESET;
         channel_control_reg   <= `CTL_RESET;
         hold_reg              <= 32'h00000000;
         rd_left_reg           <= 5'h00;
         wr_left_reg           <= 5'h00;
         done_reg              <= 1'b0;
         cfg_err_reg           <= 1'b0;
         source_bus_error_flag <= 1'b0;
         dest_bus_error_flag   <= 1'b0;
         hold_valid_reg        <= 1'b0;
         ext_start_reg         <= 1'b0;
         bw_drop_reg           <= 1'b0;
      end else begin
         bw_drop_reg <= 1'b0;
         // write-one to done clears flags and stops the channel
         if (st_clr) begin
            done_reg              <= 1'b0;
            cfg_err_reg           <= 1'b0;
            source_bus_error_flag <= 1'b0;
            dest_bus_error_flag   <= 1'b0;
         end
         // the engine runs after the clear, so a hardware set in the same cycle wins
         begin
            case (state_reg)
               S_IDLE: begin
                  if (go && !st_clr) begin // a clear holds the channel idle
                     channel_control_reg[`CTL_START] <= 1'b0;
                     ext_start_reg <= !start_bit;
                     if (cfg_bad) begin
                        cfg_err_reg <= 1'b1;
                        done_reg    <= 1'b1;
                     end else begin
                        state_reg <= S_SETUP;
                     end
                  end
               end
               S_SETUP: begin
                  rd_left_reg <= chunk_b;
                  wr_left_reg <= chunk_b;
                  state_reg   <= S_READ;
               end
               S_READ: begin
                  if (acc_go) begin
                     if (i_bus_err) begin
                        source_bus_error_flag <= 1'b1;
                        done_reg              <= 1'b1;
                        state_reg             <= S_IDLE;
                     end else begin
                        if (sar_inc) begin
                           source_address_reg <= source_address_reg + {27'h0, rd_b};
                        end
                        if (single_addr) begin
                           byte_count_reg <= count_dec;
                           done_reg       <= fin_done;
                           bw_drop_reg    <= bw_hit && !fin_done;
                           state_reg      <= fin_state;
                        end else begin
                           hold_reg       <= i_bus_rdata;
                           hold_valid_reg <= 1'b1;
                           rd_left_reg    <= rd_left_reg - rd_b;
                           if (rd_left_reg == rd_b) begin
                              state_reg <= S_WRITE;
                           end
                        end
                     end
                  end
               end
               S_WRITE: begin
                  if (acc_go) begin
                     if (i_bus_err) begin
                        dest_bus_error_flag <= 1'b1;
                        done_reg            <= 1'b1;
                        hold_valid_reg      <= 1'b0;
                        state_reg           <= S_IDLE;
                     end else begin
                        if (dar_inc) begin
                           dest_address_reg <= dest_address_reg + {27'h0, wr_b};
                        end
                        byte_count_reg <= count_dec;
                        wr_left_reg    <= wr_left_reg - wr_b;
                        if (wr_left_reg == wr_b) begin
                           hold_valid_reg <= 1'b0;
                           done_reg       <= fin_done;
                           bw_drop_reg    <= bw_hit && !fin_done;
                           state_reg      <= fin_state;
                        end
                     end
                  end
               end
               default: begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
         // a stopped channel goes idle whatever the engine chose
         if (st_clr) begin
            state_reg <= S_IDLE;
         end
         // software register writes take effect at the access edge
         if (apb_wr) begin
            case (i_paddr)
               `OFS_SRC_ADDR: source_address_reg  <= i_pwdata;
               `OFS_DST_ADDR: dest_address_reg    <= i_pwdata;
               `OFS_COUNT:    byte_count_reg      <= i_pwdata[`COUNT_W-1:0];
               `OFS_CONTROL:  channel_control_reg <= i_pwdata[`CTL_W-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // apb answers at once; unmapped addresses get an error
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !apb_hit;

   // bus side; request drops one clock at a bandwidth boundary
   assign o_bus_req      = !st_idle && !bw_drop_reg;
   assign o_bus_priority = !st_idle && (bandwidth_limit_field == 3'h0);
   assign o_bus_cycle    = st_read || st_write;
   assign o_bus_write    = st_write ||
                           (st_read && single_addr && channel_control_reg[`CTL_SINGLE_WRITE]);
   assign o_bus_addr     = st_write ? dest_address_reg : source_address_reg;
   assign o_bus_size     = st_write ? dst_pick : src_pick;
   assign o_bus_wdata    = hold_reg;
   assign o_bus_tt       = `TT_DMA;
   assign o_bus_tm       = ext_start_reg ? `TM_EXTERNAL : `TM_INTERNAL;

   // interrupt follows done, set on success or error
   assign o_irq = channel_control_reg[`CTL_INT_EN] && done_reg;

endmodule // dma_channel_transfer_control

`default_nettype wire

// ==== dma_channel_transfer_control_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dma_consts.vh"
`define check(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module dma_channel_transfer_control_test;
   logic        clock = 1'b0;
   logic        rst_b, psel, penable, pwrite, kick, slow, pready, pslverr, se;
   logic        req_n, grant, ack, err, bus_req, prio, cyc, bwr, irq;
   logic [1:0]  err_mode, bsize, tt;
   logic [2:0]  tm, last_tm;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata, baddr, bwdata, last_wdata, q;
   int          failures = 0, n_compared = 0, cycles = 0, i;
   always #5 clock = ~clock;
   dma_channel_transfer_control dma_channel_transfer_control_i (.i_clock(clock),
      .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_external_request_n(req_n), .i_bus_grant(grant),
      .i_bus_ack(ack), .i_bus_err(err), .i_bus_rdata(rdata), .o_bus_req(bus_req),
      .o_bus_priority(prio), .o_bus_cycle(cyc), .o_bus_write(bwr), .o_bus_addr(baddr),
      .o_bus_size(bsize), .o_bus_wdata(bwdata), .o_bus_tt(tt), .o_bus_tm(tm), .o_irq(irq));
   dma_far_side_model dma_far_side_model_i (.i_clock(clock), .i_rst_b(rst_b),
      .i_kick(kick), .i_slow(slow), .i_err_mode(err_mode), .i_bus_req(bus_req),
      .i_bus_cycle(cyc), .i_bus_write(bwr), .i_bus_addr(baddr), .i_bus_wdata(bwdata),
      .i_bus_tm(tm), .o_request_n(req_n), .o_grant(grant), .o_ack(ack), .o_err(err),
      .o_rdata(rdata), .o_last_wdata(last_wdata), .o_last_tm(last_tm));
   task automatic give_verdict();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer; the request stands until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic expect_reg(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `check(q, e)
   endtask
   // polls a register bit; the cycle ceiling catches a hang
   task automatic wait_bit(input logic [11:0] a, input int b, input logic v);
      do apb(1'b0, a, 32'h0); while (q[b] !== v);
   endtask
   task automatic run(input logic [31:0] s, d, c, ctl);
      apb(1'b1, `OFS_SRC_ADDR, s);
      apb(1'b1, `OFS_DST_ADDR, d);
      apb(1'b1, `OFS_COUNT, c);
      apb(1'b1, `OFS_CONTROL, ctl);
   endtask
   task automatic pulse();
      kick <= 1'b1;
      @(posedge clock);
      kick <= 1'b0;
   endtask
   // write-one clear, then control off so nothing restarts
   task automatic clear();
      apb(1'b1, `OFS_STATUS, 32'h1);
      @(negedge clock);
      `check(irq, 1'b0)
      apb(1'b1, `OFS_CONTROL, 32'h0);
      apb(1'b0, `OFS_STATUS, 32'h0);
      `check(q[4:0], 5'h00)
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      {rst_b, psel, penable, pwrite, kick, slow, err_mode, paddr, pwdata} = '0;
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      // every register reads zero after reset; the sixth offset is unmapped
      for (i = 0; i < 6; i++) expect_reg(12'(i * 4), 32'h0);
      `check(se, 1'b1)
      // dual long block under grant stealing
      slow <= 1'b1;
      run(32'h1000, 32'h2000, 32'h8, 32'h4061);
      wait_bit(`OFS_STATUS, 0, 1'b1);
      `check(q[4:0], 5'h01)
      `check(irq, 1'b1)
      expect_reg(`OFS_SRC_ADDR, 32'h1008);
      expect_reg(`OFS_DST_ADDR, 32'h2008);
      expect_reg(`OFS_COUNT, 32'h0);
      expect_reg(`OFS_CONTROL, 32'h4060);
      `check(se, 1'b0)
      `check(last_wdata, 32'hEFFB1004)
      `check(last_tm, `TM_INTERNAL)
      clear();
      slow <= 1'b0;
      // misaligned source: nothing moves
      run(32'h1001, 32'h2000, 32'h8, 32'h4062);
      pulse();
      wait_bit(`OFS_STATUS, 2, 1'b1);
      expect_reg(`OFS_COUNT, 32'h8);
      `check(last_wdata, 32'hEFFB1004)
      clear();
      // read error, then write error
      for (i = 0; i < 2; i++) begin
         err_mode <= 2'h1 << i;
         run(32'h1000, 32'h2000, 32'h8, 32'h4061);
         wait_bit(`OFS_STATUS, 0, 1'b1);
         err_mode <= 2'h0;
         `check(q[4:3], i ? 2'h2 : 2'h1)
         `check(irq, 1'b1)
         expect_reg(`OFS_COUNT, 32'h8);
         clear();
      end
      // cycle steal from the external line: one transfer per request
      run(32'h3000, 32'h4000, 32'h8, 32'h4066);
      pulse();
      wait_bit(`OFS_COUNT, 2, 1'b1);
      wait_bit(`OFS_STATUS, 1, 1'b0);
      `check(q[0], 1'b0)
      expect_reg(`OFS_COUNT, 32'h4);
      `check(last_tm, `TM_EXTERNAL)
      `check(last_wdata, 32'hCFFF3000)
      pulse();
      wait_bit(`OFS_STATUS, 0, 1'b1);
      expect_reg(`OFS_COUNT, 32'h0);
      clear();
      // auto-align with odd source and source increment off
      run(32'h5001, 32'h6000, 32'h14, 32'h4249);
      wait_bit(`OFS_STATUS, 0, 1'b1);
      `check(q[4:0], 5'h01)
      expect_reg(`OFS_SRC_ADDR, 32'h5015);
      expect_reg(`OFS_DST_ADDR, 32'h6014);
      expect_reg(`OFS_COUNT, 32'h0);
      clear();
      // single-address writes with bandwidth field one: one boundary crossed
      run(32'h7000, 32'h0, 32'h204, 32'hC871);
      wait_bit(`OFS_STATUS, 0, 1'b1);
      `check(q[4:0], 5'h01)
      expect_reg(`OFS_SRC_ADDR, 32'h7204);
      expect_reg(`OFS_COUNT, 32'h0);
      clear();
      give_verdict();
   end
endmodule // dma_channel_transfer_control_test
`default_nettype wire

// ==== dma_consts.vh ====
`ifndef DMA_CONSTS_VH
`define DMA_CONSTS_VH

// register byte offsets on the apb side
`define OFS_SRC_ADDR     12'h000
`define OFS_DST_ADDR     12'h004
`define OFS_COUNT        12'h008
`define OFS_CONTROL      12'h00C
`define OFS_STATUS       12'h010

// widths and reset values
`define COUNT_W          24
`define CTL_W            16
`define CTL_RESET        16'h0000
`define ADDR_RESET       32'h00000000
`define COUNT_RESET      24'h000000

// channel_control_reg fields
`define CTL_START        0
`define CTL_EXT_EN       1
`define CTL_CYCLE_STEAL  2
`define CTL_AUTO_ALIGN   3
`define CTL_SINGLE_ADDR  4
`define CTL_SRC_INC      5
`define CTL_DST_INC      6
`define CTL_SOURCE_OPERAND_SIZE_LO     7
`define CTL_DEST_OPERAND_SIZE_LO     9
`define CTL_BW_LO        11
`define CTL_INT_EN       14
`define CTL_SINGLE_WRITE 15

// status register fields
`define ST_DONE          0
`define ST_BUSY          1
`define ST_CFG_ERR       2
`define ST_SRC_ERR       3
`define ST_DST_ERR       4
`define ST_HOLD_VALID    5

// operand size codes
`define SZ_LONG          2'h0
`define SZ_BYTE          2'h1
`define SZ_WORD          2'h2
`define SZ_LINE          2'h3

// transfer mode and modifier codes
`define TT_DMA           2'h1
`define TM_INTERNAL      3'h0
`define TM_EXTERNAL      3'h1

// bandwidth block is 1 << (field + base)
`define BW_SHIFT_BASE    5'h08
`define LINE_BYTES       5'h10

`endif

// ==== dma_far_side_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dma_far_side_model #(parameter int HOLD = 3) (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_kick,
   input  wire logic        i_slow,
   input  wire logic [1:0]  i_err_mode,
   input  wire logic        i_bus_req,
   input  wire logic        i_bus_cycle,
   input  wire logic        i_bus_write,
   input  wire logic [31:0] i_bus_addr,
   input  wire logic [31:0] i_bus_wdata,
   input  wire logic [2:0]  i_bus_tm,
   output wire logic        o_request_n,
   output var  logic        o_grant,
   output var  logic        o_ack,
   output var  logic        o_err,
   output var  logic [31:0] o_rdata,
   output var  logic [31:0] o_last_wdata,
   output var  logic [2:0]  o_last_tm
);
   logic [2:0] hold_cnt;
   logic [2:0] tick;
   wire  logic ack_now = i_bus_cycle && o_grant && !o_ack && !(i_slow && tick[0]);
   // short request pulse, well inside the single-transfer limit
   assign o_request_n = (hold_cnt == 3'h0);
   // arbiter, memory and peripheral; slow mode stretches acks and steals grant
   always @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         hold_cnt <= 3'h0;
         tick <= 3'h0;
         o_grant <= 1'b0;
         o_ack <= 1'b0;
         o_err <= 1'b0;
         o_rdata <= 32'h0;
         o_last_wdata <= 32'h0;
         o_last_tm <= 3'h0;
      end else begin
         hold_cnt <= i_kick ? 3'(HOLD) : (hold_cnt == 3'h0 ? 3'h0 : hold_cnt - 3'h1);
         tick <= tick + 3'h1;
         o_grant <= i_bus_req && !(i_slow && tick == 3'h5);
         o_ack <= ack_now;
         o_err <= ack_now && i_err_mode[i_bus_write];
         // idle data bus flips so stale data never looks valid
         o_rdata <= ack_now ? {~i_bus_addr[15:0], i_bus_addr[15:0]} : ~o_rdata;
         if (i_bus_cycle && o_grant && o_ack && i_bus_write && !o_err) begin
            o_last_wdata <= i_bus_wdata;
            o_last_tm <= i_bus_tm;
         end
      end
   end
endmodule // dma_far_side_model
`default_nettype wire

// ==== dma_req_sync.v ====
`timescale 1ns/1ns
`default_nettype none

module dma_req_sync (
   input  wire i_clock,
   input  wire i_rst_b,
   input  wire i_request_n,
   output wire o_request
);

   reg meta_reg;
   reg sync_reg;

   // two stages; the first is read only by the second
   always @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
      end else begin
         meta_reg <= i_request_n;
         sync_reg <= meta_reg;
      end
   end

   assign o_request = ~sync_reg;

endmodule // dma_req_sync

`default_nettype wire

// ==== dma_size_sel.v ====
`timescale 1ns/1ns
`default_nettype none
`include "dma_consts.vh"

module dma_size_sel (
   input  wire                 i_align,
   input  wire [3:0]           i_addr,
   input  wire [1:0]           i_prog_size,
   input  wire [`COUNT_W-1:0]  i_count,
   input  wire [4:0]           i_limit,
   output reg  [1:0]           o_size
);

   reg [4:0] lim;
   reg [4:0] cap;

   function [4:0] size_bytes;
      input [1:0] s;
      begin
         case (s)
            `SZ_BYTE: size_bytes = 5'h01;
            `SZ_WORD: size_bytes = 5'h02;
            `SZ_LINE: size_bytes = 5'h10;
            default:  size_bytes = 5'h04;
         endcase
      end
   endfunction

   // size fits the byte limit, the cap and the address alignment
   function fits;
      input [1:0] s;
      input [3:0] a;
      input [4:0] l;
      input [4:0] c;
      reg   [4:0] b;
      begin
         b = size_bytes(s);
         fits = (b <= l) && (b <= c) && ((a & (b[3:0] - 4'h1)) == 4'h0);
      end
   endfunction

   // largest legal size; below 16 bytes the remaining count rules
   always @* begin
      lim = i_limit;
      if (i_count < 24'h000010 && i_count[4:0] < lim) begin
         lim = i_count[4:0];
      end
      cap = size_bytes(i_prog_size);
      if (!i_align) begin
         o_size = i_prog_size;
      end else if (fits(`SZ_LINE, i_addr, lim, cap)) begin
         o_size = `SZ_LINE;
      end else if (fits(`SZ_LONG, i_addr, lim, cap)) begin
         o_size = `SZ_LONG;
      end else if (fits(`SZ_WORD, i_addr, lim, cap)) begin
         o_size = `SZ_WORD;
      end else begin
         o_size = `SZ_BYTE;
      end
   end

endmodule // dma_size_sel

`default_nettype wire

// ==== dma_transfer_checker_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dma_consts.vh"
module dma_transfer_checker (
   input wire logic        i_clock,
   input wire logic        i_rst_b,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic        i_bus_grant,
   input wire logic        i_bus_ack,
   input wire logic        i_bus_err,
   input wire logic [31:0] i_bus_rdata,
   input wire logic        o_bus_req,
   input wire logic        o_bus_priority,
   input wire logic        o_bus_cycle,
   input wire logic        o_bus_write,
   input wire logic [31:0] o_bus_addr,
   input wire logic [1:0]  o_bus_size,
   input wire logic [31:0] o_bus_wdata,
   input wire logic [1:0]  o_bus_tt,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   // a cycle only completes where grant and ack meet
   wire logic       fin = o_bus_cycle && i_bus_grant && i_bus_ack;
   wire logic       apw = i_psel && i_penable && i_pwrite;
   wire logic       clr = apw && i_paddr == `OFS_STATUS && i_pwdata[0];
   wire logic [3:0] amask = o_bus_size == `SZ_BYTE ? 4'h0 : o_bus_size == `SZ_WORD ? 4'h1 :
                            o_bus_size == `SZ_LONG ? 4'h3 : 4'hF;
   tt_marks_dma_a: assert property (o_bus_cycle |-> o_bus_tt == `TT_DMA)
      else $error("cycle not typed dma");
   prio_keeps_req_a: assert property (o_bus_priority |-> o_bus_req)
      else $error("priority without request");
   error_halts_a: assert property (fin && i_bus_err |=> !o_bus_cycle [*6])
      else $error("cycle after bus error");
   clear_drops_irq_a: assert property (clr && !o_bus_cycle |=> !o_irq)
      else $error("irq after clear");
   irq_holds_a: assert property (o_irq && !clr && !(apw && i_paddr == `OFS_CONTROL)
      |=> o_irq)
      else $error("irq dropped early");
   size_aligned_a: assert property (o_bus_cycle |-> (o_bus_addr[3:0] & amask) == 4'h0)
      else $error("access wider than address allows");
   addr_held_a: assert property (o_bus_cycle && !fin && !apw |=> $stable(o_bus_addr))
      else $error("address moved while stalled");
   wdata_copy_a: assert property (fin && !o_bus_write && !i_bus_err && o_bus_size == `SZ_LONG
      ##1 o_bus_write && o_bus_size == `SZ_LONG |-> o_bus_wdata == $past(i_bus_rdata))
      else $error("write data not the read data");
   cover property (fin && i_bus_err);
   cover property (o_bus_priority && fin);
   cover property (clr && o_irq);
   cover property (o_bus_cycle ##1 !o_bus_req ##1 o_bus_req);
endmodule // dma_transfer_checker
bind dma_channel_transfer_control dma_transfer_checker dma_transfer_checker_i (
   .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_bus_grant(i_bus_grant),
   .i_bus_ack(i_bus_ack), .i_bus_err(i_bus_err), .i_bus_rdata(i_bus_rdata),
   .o_bus_req(o_bus_req), .o_bus_priority(o_bus_priority), .o_bus_cycle(o_bus_cycle),
   .o_bus_write(o_bus_write), .o_bus_addr(o_bus_addr), .o_bus_size(o_bus_size),
   .o_bus_wdata(o_bus_wdata), .o_bus_tt(o_bus_tt), .o_irq(o_irq));
`default_nettype wire

// ==== dummy_end_marker_none.v ====
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
